// >>> verilog/motor_msg_cfg.svh
// Constants of the motor message handler
`ifndef MOTOR_MSG_CFG_SVH
`define MOTOR_MSG_CFG_SVH
`define FC_DRIVE        4'h3
`define FC_RSVD_A       4'h4
`define FC_STATE1       4'h5
`define FC_ERRSTATE     4'h6
`define FC_STATE2       4'h7
`define FC_RSVD_B       4'h8
`define FC_CTRL_SET     4'h9
`define FC_FLAG_SET     4'ha
`define FC_PARAM_REQ    4'hb
`define FC_PARAM_REPLY  4'hc
`define NODE_DEFAULT    7'h01
`define WID_NODE        8'h10
`define WID_POWERUP     8'h11
`define PARAM_WRITE     8'h3b
`define PARAM_READ      8'h21
`define PARAM_OK        8'h01
`define PARAM_NG        8'h00
`define LIM_CURRENT     16'd370
`define LIM_SPEED       16'd4000
`define LIM_ACCEL       16'd32767
`define CLK_HZ          100000000
`define TIMEOUT_MS      500
`define TIMEOUT_CYC     (`CLK_HZ / 1000 * `TIMEOUT_MS)
`define TICK_MS         10
`define TICK_CYC        (`CLK_HZ / 1000 * `TICK_MS)
`define ERR_COMM        16'h0001
`define INTERVAL_RST    8'h01
`endif

// >>> verilog/motor_msg_pkg.sv
// Types of the motor message handler
package motor_msg_pkg;
	// One CAN frame, standard identifier
	typedef struct packed {
		logic [10:0]     id;
		logic [3:0]      len;
		logic [7:0][7:0] data;   // data[7] is first byte
	} frame_s;
	// Drive command as applied to the motor
	typedef struct packed {
		logic        run;
		logic        cw;
		logic [15:0] speed;
		logic [15:0] accel;
		logic [15:0] ilim;
	} drive_s;
	// Live measurements from the motor stage
	typedef struct packed {
		logic [15:0] speed;
		logic [15:0] current;
		logic [15:0] torque;
		logic [7:0]  temp1;
		logic [31:0] distance;
		logic [15:0] dc_volt;
		logic [7:0]  temp2;
		logic [15:0] warn;
	} meas_s;
	// Transmit scheduler states, Gray along the cycle
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_S1   = 2'b01,
		TX_ERR  = 2'b11,
		TX_S2   = 2'b10
	} tx_state_e;
endpackage

// >>> verilog/motor_msg.sv
// Application message handler of the motor controller
`timescale 1ns/1ps
`include "motor_msg_cfg.svh"
module motor_msg #(
	parameter int TIMEOUT_CYC = `TIMEOUT_CYC,  // Watchdog length
	parameter int TICK_CYC    = `TICK_CYC      // Report time base
) (
	// Clock and reset
	input  wire logic                  i_clk,
	input  wire logic                  i_rst_n,
	// Received frames
	input  wire logic                  i_rx_valid,
	input  wire motor_msg_pkg::frame_s i_rx_frame,
	// Transmit frames
	input  wire logic                  i_tx_ready,
	output logic                       o_tx_valid,
	output motor_msg_pkg::frame_s      o_tx_frame,
	// Motor side
	input  wire motor_msg_pkg::meas_s  i_meas,
	output motor_msg_pkg::drive_s      o_drive,
	output logic                       o_dist_clear,
	// Status and saved settings
	input  wire logic                  i_powerup_report,
	output logic                       o_comm_error,
	output logic [6:0]                 o_node_identifier,
	output logic                       o_powerup_report
);
	////////////////////////////////////////////////////////////
	// Helpers
	// Clamp a value to an upper limit
	function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
		return (v > lim) ? lim : v;
	endfunction
	// Identifier from code and node
	function automatic logic [10:0] make_id(input logic [3:0] fc, input logic [6:0] node);
		return {fc, node};  // Same as fc*0x80+node
	endfunction

	////////////////////////////////////////////////////////////
	// State
	motor_msg_pkg::drive_s     drive_q, drive_d;       // Applied command
	logic [6:0]                node_q, node_d;         // Own node id
	logic                      report_q, report_d;     // Reporting enabled
	logic                      pu_q, pu_d;             // Saved power-up report
	logic [7:0]                ivl_q, ivl_d;           // Report interval setting
	logic                      err_q, err_d;           // Communication error
	logic [31:0]               wd_q, wd_d;             // Watchdog counter
	logic [31:0]               tick_q, tick_d;         // 10 ms divider
	logic [7:0]                per_q, per_d;           // Interval counter
	logic                      clr_q, clr_d;           // Distance clear pulse
	logic                      reply_q, reply_d;       // Reply pending
	logic                      rep_q, rep_d;           // Report burst pending
	motor_msg_pkg::frame_s     rframe_q, rframe_d;     // Reply frame
	motor_msg_pkg::tx_state_e  st_q, st_d;             // Transmit sequence
	logic                      txv_q, txv_d;           // Transmit valid
	motor_msg_pkg::frame_s     txf_q, txf_d;           // Transmit frame
	logic                      tick;                   // 10 ms enable
	logic                      due;                    // Report period elapsed
	logic                      mine;                   // Frame for this node
	logic [3:0]                fc;                     // Received code
	logic [7:0][7:0]           rd;                     // Received bytes

	assign fc   = i_rx_frame.id[10:7];
	assign rd   = i_rx_frame.data;
	assign mine = i_rx_valid && (i_rx_frame.id[6:0] == node_q);
	assign tick = (tick_q == 32'(TICK_CYC - 1));
	assign due  = tick && (per_q >= ivl_q);

	////////////////////////////////////////////////////////////
	// Next-state of decoder, watchdog and scheduler
	always_comb begin
		drive_d  = drive_q;
		node_d   = node_q;
		report_d = report_q;
		pu_d     = pu_q;
		ivl_d    = ivl_q;
		err_d    = err_q;
		clr_d    = 1'b0;
		reply_d  = reply_q;
		rep_d    = rep_q;
		rframe_d = rframe_q;
		st_d     = st_q;
		txv_d    = txv_q;
		txf_d    = txf_q;
		// Time base divider
		tick_d = tick ? 32'h0 : tick_q + 32'h1;
		// Interval counter restarts each time the report period elapses
		per_d = per_q;
		if (due) begin
			per_d = 8'h0;
		end else if (tick) begin
			per_d = per_q + 8'h1;
		end
		// Watchdog counts up and holds at TIMEOUT_CYC; a drive command restarts it
		wd_d = (wd_q == 32'(TIMEOUT_CYC)) ? wd_q : wd_q + 32'h1;
		// Frame decode; other codes fall through untouched
		if (mine) begin
			case (fc)
				`FC_DRIVE: begin
					// Big-endian fields
					wd_d        = 32'h0;
					drive_d.run = rd[7][1] && !err_q;
					drive_d.cw  = rd[7][2];
					drive_d.speed = clamp({rd[6], rd[5]}, `LIM_SPEED);
					drive_d.accel = clamp({rd[4], rd[3]}, `LIM_ACCEL);
					drive_d.ilim  = clamp({rd[2], rd[1]}, `LIM_CURRENT);
					if (!rd[7][1]) begin
						err_d = 1'b0;  // A stop command clears the error
					end
				end
				`FC_CTRL_SET: begin
					report_d = rd[6][0];
					ivl_d    = rd[5];
				end
				`FC_FLAG_SET: begin
					clr_d = rd[7][1];
				end
				`FC_PARAM_REQ: begin
					// Reply layout: length, result, id, data
					rframe_d.id   = make_id(`FC_PARAM_REPLY, node_q);
					rframe_d.len  = 4'h8;
					rframe_d.data = rd;
					rframe_d.data[6] = `PARAM_NG;
					reply_d = 1'b1;
					if (rd[6] == `PARAM_WRITE) begin
						rframe_d.data[6] = `PARAM_OK;
						if (rd[5] == `WID_NODE) begin
							node_d = rd[4][6:0];
						end else if (rd[5] == `WID_POWERUP) begin
							pu_d = rd[4][0];
						end else begin
							rframe_d.data[6] = `PARAM_NG;
						end
					end else if (rd[6] == `PARAM_READ) begin
						rframe_d.data[6] = `PARAM_OK;
						rframe_d.data[7] = 8'h01;
						if (rd[5] == `WID_NODE) begin
							rframe_d.data[4] = {1'b0, node_q};
						end else if (rd[5] == `WID_POWERUP) begin
							rframe_d.data[4] = {7'h0, pu_q};
						end else begin
							rframe_d.data[6] = `PARAM_NG;
						end
					end
				end
				default: begin
					// Reserved and unknown codes ignored
				end
			endcase
		end
		// Timeout only when no drive frame lands this cycle, so run never rises with the error
		if (wd_q == 32'(TIMEOUT_CYC - 1) && wd_d != 32'h0) begin
			err_d       = 1'b1;
			drive_d.run = 1'b0;
		end
		// Transmit scheduler
		if (txv_q && i_tx_ready) begin
			txv_d = 1'b0;
		end
		if (!txv_q || i_tx_ready) begin
			case (st_q)
				motor_msg_pkg::TX_IDLE: begin
					if (reply_q) begin
						txv_d   = 1'b1;
						txf_d   = rframe_q;
						reply_d = mine && (fc == `FC_PARAM_REQ);
					end else if (rep_q) begin
						st_d  = motor_msg_pkg::TX_S1;
						rep_d = 1'b0;
					end
				end
				motor_msg_pkg::TX_S1: begin
					txv_d = 1'b1;
					txf_d.id   = make_id(`FC_STATE1, node_q);
					txf_d.len  = 4'h8;
					txf_d.data = {i_meas.speed, i_meas.current, i_meas.torque, i_meas.temp1, 8'h0};
					st_d = motor_msg_pkg::TX_ERR;
				end
				motor_msg_pkg::TX_ERR: begin
					txv_d = 1'b1;
					txf_d.id   = make_id(`FC_ERRSTATE, node_q);
					txf_d.len  = 4'h4;
					txf_d.data = {(err_q ? `ERR_COMM : 16'h0), i_meas.warn, 32'h0};
					st_d = motor_msg_pkg::TX_S2;
				end
				motor_msg_pkg::TX_S2: begin
					txv_d = 1'b1;
					txf_d.id   = make_id(`FC_STATE2, node_q);
					txf_d.len  = 4'h8;
					txf_d.data = {i_meas.distance, i_meas.dc_volt, 8'h0, i_meas.temp2};
					st_d = motor_msg_pkg::TX_IDLE;
				end
				default: begin
					st_d = motor_msg_pkg::TX_IDLE;
				end
			endcase
		end
		// Period elapsed: burst waits until the sender is free; set wins
		if (report_q && due) begin
			rep_d = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			drive_q  <= '0;
			node_q   <= `NODE_DEFAULT;
			report_q <= i_powerup_report;  // Saved power-up report setting
			pu_q     <= i_powerup_report;
			rep_q    <= 1'b0;
			ivl_q    <= `INTERVAL_RST;
			err_q    <= 1'b0;
			wd_q     <= 32'h0;
			tick_q   <= 32'h0;
			per_q    <= 8'h0;
			clr_q    <= 1'b0;
			reply_q  <= 1'b0;
			rframe_q <= '0;
			st_q     <= motor_msg_pkg::TX_IDLE;
			txv_q    <= 1'b0;
			txf_q    <= '0;
		end else begin
			drive_q  <= drive_d;
			node_q   <= node_d;
			report_q <= report_d;
			pu_q     <= pu_d;
			ivl_q    <= ivl_d;
			err_q    <= err_d;
			wd_q     <= wd_d;
			tick_q   <= tick_d;
			per_q    <= per_d;
			clr_q    <= clr_d;
			reply_q  <= reply_d;
			rframe_q <= rframe_d;
			st_q     <= st_d;
			txv_q    <= txv_d;
			txf_q    <= txf_d;
			rep_q    <= rep_d;
		end
	end

	// Outputs straight from flip-flops
	assign o_tx_valid        = txv_q;
	assign o_tx_frame        = txf_q;
	assign o_drive           = drive_q;
	assign o_dist_clear      = clr_q;
	assign o_comm_error      = err_q;
	assign o_node_identifier = node_q;
	assign o_powerup_report  = pu_q;
endmodule

// >>> dv/motor_msg_properties.sv
// Port checker of the motor message handler
`timescale 1ns/1ps
module motor_msg_checker #(
	parameter int TIMEOUT_CYC = 200  // Watchdog length
) (
	// Clock and reset
	input wire logic                  i_clk,
	input wire logic                  i_rst_n,
	// Frame interfaces
	input wire logic                  i_rx_valid,
	input wire motor_msg_pkg::frame_s i_rx_frame,
	input wire logic                  i_tx_ready,
	input wire logic                  o_tx_valid,
	input wire motor_msg_pkg::frame_s o_tx_frame,
	// Motor side and status
	input wire motor_msg_pkg::drive_s o_drive,
	input wire logic                  o_dist_clear,
	input wire logic                  o_comm_error,
	input wire logic [6:0]            o_node_identifier
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	////////////////////////////////////////////////////////////////
	// Decoded request seen on the receive side
	logic [15:0] exp_speed;  // Requested speed after clamping
	logic [3:0]  rx_code;    // Function code of the offered frame
	assign rx_code = i_rx_frame.id[10:7];
	assign exp_speed = ({i_rx_frame.data[6], i_rx_frame.data[5]} > 16'h0fa0) ? 16'h0fa0
		: {i_rx_frame.data[6], i_rx_frame.data[5]};
	// Cycles since the last drive frame for this node, saturating
	logic [31:0] quiet_q;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n || (i_rx_valid && i_rx_frame.id == {4'h3, o_node_identifier})) begin
			quiet_q <= 32'h0;
		end else if (quiet_q != 32'(TIMEOUT_CYC)) begin
			quiet_q <= quiet_q + 32'h1;
		end
	end
	////////////////////////////////////////////////////////////////
	// Assertions
	drive_take_a: assert property (i_rx_valid && i_rx_frame.id == {4'h3, o_node_identifier} && !o_comm_error
		|=> o_drive.speed == $past(exp_speed) && o_drive.cw == $past(i_rx_frame.data[7][2])) else $error("drive");
	tx_hold_a: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_frame))
		else $error("tx frame not held");
	tx_node_a: assert property (o_tx_valid && o_tx_frame.id[10:7] != 4'hc
		|-> o_tx_frame.id[6:0] == o_node_identifier) else $error("tx node");
	tx_code_a: assert property (o_tx_valid |-> o_tx_frame.id[10:7] inside {4'h5, 4'h6, 4'h7, 4'hc})
		else $error("tx code");
	value_clamp_a: assert property (o_drive.ilim <= 16'h0172 && o_drive.speed <= 16'h0fa0
		&& o_drive.accel <= 16'h7fff) else $error("clamp");
	error_stop_a: assert property (o_comm_error |-> !o_drive.run) else $error("run in error");
	rsvd_ignore_a: assert property (i_rx_valid && rx_code inside {4'h4, 4'h8}
		|=> $stable(o_drive) && $stable(o_node_identifier)) else $error("reserved acted on");
	dist_pulse_a: assert property (i_rx_valid && i_rx_frame.id == {4'ha, o_node_identifier}
		&& i_rx_frame.data[7][1] |=> o_dist_clear ##1 !o_dist_clear) else $error("clear pulse");
	reset_node_a: assert property ($rose(i_rst_n) |-> o_node_identifier == 7'h01 && !o_tx_valid)
		else $error("reset state");
	comm_timeout_a: assert property (quiet_q == 32'(TIMEOUT_CYC) |-> o_comm_error)
		else $error("no timeout error");
	// Main scenarios
	cover property (o_tx_valid && i_tx_ready);
	cover property ($rose(o_comm_error));
	cover property (o_dist_clear);
	cover property (o_tx_valid && o_tx_frame.id[10:7] == 4'h5);
endmodule
bind motor_msg motor_msg_checker #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_chk (.i_clk, .i_rst_n,
	.i_rx_valid, .i_rx_frame, .i_tx_ready, .o_tx_valid, .o_tx_frame, .o_drive, .o_dist_clear, .o_comm_error,
	.o_node_identifier);

// >>> dv/host_model.sv
// Host controller model on the far side of the frame ports
`timescale 1ns/1ps
module host_model (
	// Clock
	input  wire logic                  i_clk,
	// Frames from the controller
	input  wire logic                  i_tx_valid,
	input  wire motor_msg_pkg::frame_s i_tx_frame,
	output logic                       o_tx_ready,
	// Frames to the controller
	output logic                       o_rx_valid,
	output motor_msg_pkg::frame_s      o_rx_frame
);
	motor_msg_pkg::frame_s last [16];  // Last taken frame per code
	logic [1:0]            stall_q = 2'h0;  // Stall phase
	initial begin
		o_rx_valid = 1'b0;
		o_rx_frame = '0;
	end
	////////////////////////////////////////////////////////////////
	// Ready low one cycle in four, so offered frames must wait
	always @(negedge i_clk) begin
		stall_q <= stall_q + 2'h1;
		o_tx_ready <= (stall_q != 2'h3);
	end
	// Keep each taken frame under its code
	always @(posedge i_clk) begin
		if (i_tx_valid && o_tx_ready) begin
			last[i_tx_frame.id[10:7]] <= i_tx_frame;
		end
	end
	// One frame for one cycle, then the lines carry garbage
	// Nodes used stay clear of the reprogramming identifiers
	task automatic send(input logic [3:0] code, input logic [6:0] node, input logic [63:0] data);
		@(negedge i_clk);
		o_rx_frame = {code, node, 4'h8, data};
		o_rx_valid = 1'b1;
		@(negedge i_clk);
		o_rx_valid = 1'b0;
		o_rx_frame = ~o_rx_frame;
	endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench of the motor message handler
`timescale 1ns/1ps
module testbench;
	logic                  i_clk = 1'b0;    // Core clock
	logic                  i_rst_n = 1'b0;  // Reset, active low
	logic                  rx_valid, tx_ready, tx_valid, dist_clear, comm_error, powerup;
	motor_msg_pkg::frame_s rx_frame, tx_frame;
	motor_msg_pkg::drive_s drive;
	logic [6:0]            node;
	logic                  dist_seen = 1'b0;  // Clear pulse seen
	logic [10:0]           bad [4] = '{11'h182, 11'h201, 11'h401, 11'h681};  // Frames to be ignored
	motor_msg_pkg::meas_s  meas = '{16'h8123, 16'hff10, 16'h0321, 8'h2a, 32'hfedcba98, 16'h01f4, 8'h33, 16'h00aa};
	int                    failures = 0;
	int                    total_checks = 0;
	time                   s1_last = 0;       // Start of the last state 1 offer
	time                   s1_gap = 0;        // Spacing of the last two offers
	logic                  s1_on = 1'b0;      // State 1 offered at the last falling edge
	int                    s1_cnt = 0;        // State 1 offers seen
	int                    s1_hold = 0;       // Offers seen once reporting stopped
	always #5 i_clk = ~i_clk;
	////////////////////////////////////////////////////////////////
	// Design and host
	motor_msg #(.TIMEOUT_CYC(200), .TICK_CYC(20)) u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_rx_valid(rx_valid),
		.i_rx_frame(rx_frame), .i_tx_ready(tx_ready), .o_tx_valid(tx_valid), .o_tx_frame(tx_frame), .i_meas(meas),
		.o_drive(drive), .o_dist_clear(dist_clear), .i_powerup_report(1'b1), .o_comm_error(comm_error),
		.o_node_identifier(node), .o_powerup_report(powerup));
	host_model u_host (.i_clk(i_clk), .i_tx_valid(tx_valid), .i_tx_frame(tx_frame), .o_tx_ready(tx_ready),
		.o_rx_valid(rx_valid), .o_rx_frame(rx_frame));
	always @(posedge i_clk) if (dist_clear) dist_seen <= 1'b1;
	// Spacing and count of state 1 offers, taken where outputs are settled
	always @(negedge i_clk) begin
		s1_on <= tx_valid && tx_frame.id[10:7] == 4'h5;
		if (tx_valid && tx_frame.id[10:7] == 4'h5 && !s1_on) begin
			s1_gap  <= $time - s1_last;
			s1_last <= $time;
			s1_cnt  <= s1_cnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	// Compare and close
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	initial begin
		#50000;
		failures++;
		test_done();
	end
	// Main sequence
	initial begin
		repeat (3) @(negedge i_clk);
		i_rst_n = 1'b1;
		chk({node, powerup, drive, tx_valid}, {7'h01, 1'b1, 50'h0, 1'b0});
		repeat (120) @(negedge i_clk); // Scaled quiet time after startup
		u_host.send(4'h3, 7'h01, 64'h0613888000019000);
		repeat (2) @(negedge i_clk);
		chk(drive, {2'b11, 16'h0fa0, 16'h7fff, 16'h0172});
		for (int k = 0; k < 4; k++) u_host.send(bad[k][10:7], bad[k][6:0], 64'h0);
		repeat (2) @(negedge i_clk);
		chk(drive, {2'b11, 16'h0fa0, 16'h7fff, 16'h0172});
		u_host.send(4'ha, 7'h01, 64'h0200000000000000);
		repeat (2) @(negedge i_clk);
		chk(dist_seen, 1'b1);
		u_host.send(4'hb, 7'h01, 64'h013b110000000000);
		repeat (2) @(negedge i_clk);
		chk(powerup, 1'b0);
		repeat (120) @(negedge i_clk);
		chk({u_host.last[5].id, u_host.last[5].data}, {11'h281, 64'h8123ff1003212a00});
		chk({u_host.last[7].id, u_host.last[7].data}, {11'h381, 64'hfedcba9801f40033});
		chk({u_host.last[6].id, u_host.last[6].len, u_host.last[6].data[7:4]}, {11'h301, 4'h4, 32'h000000aa});
		chk({u_host.last[12].id, u_host.last[12].data}, {11'h601, 64'h0101110000000000});
		chk(s1_gap, 64'h190); // (1+1) x 20 cycles of 10 ns
		repeat (200) @(negedge i_clk);
		chk({comm_error, drive.run}, 2'b10);
		u_host.send(4'h3, 7'h01, 64'h0200000000000000);
		repeat (2) @(negedge i_clk);
		chk({comm_error, drive.run}, 2'b10);
		repeat (90) @(negedge i_clk);
		chk(u_host.last[6].data[7:4], 32'h000100aa);
		u_host.send(4'hb, 7'h01, 64'h013b100200000000);
		repeat (2) @(negedge i_clk);
		chk(node, 7'h02);
		u_host.send(4'h3, 7'h02, 64'h0);
		repeat (2) @(negedge i_clk);
		chk({comm_error, drive.run}, 2'b00);
		u_host.send(4'h9, 7'h02, 64'h0101030000000000);
		repeat (250) @(negedge i_clk);
		chk(s1_gap, 64'h320); // (3+1) x 20 cycles of 10 ns
		u_host.send(4'h9, 7'h02, 64'h0100030000000000);
		repeat (10) @(negedge i_clk);
		s1_hold = s1_cnt;
		repeat (200) @(negedge i_clk);
		chk(s1_cnt, s1_hold);
		test_done();
	end
endmodule
